// File: verif/bac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bac_host_model (
  // Clock.
  input  wire logic             mclk,
  // Register port.
  output var bac_pkg::bac_req_t reg_req,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid
);
  initial reg_req = '0;

  // Released address and data lines toggle, so a stale value never looks live.
  task automatic release_bus();
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    release_bus();
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req.wdata};
    @(negedge mclk);
    v = reg_rvalid;
    d = reg_rdata;
    release_bus();
  endtask

  // The upper byte is fetched first; it freezes the lower byte for the second read.
  task automatic rd_conv(output logic [11:0] r, output logic [1:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(bac_pkg::ADR_CONV_HI, hi, v[1]);
    rd(bac_pkg::ADR_CONV_LO, lo, v[0]);
    r = {hi[3:0], lo};
  endtask
endmodule
`default_nettype wire

// File: verif/bac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boost_and_sensor_adc_control_tb;
  localparam int SOFT = 100;
  localparam int SMP  = 20;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  bac_pkg::bac_req_t reg_req;
  logic [7:0]        reg_rdata;
  logic              reg_rvalid;
  logic              conv_start;
  logic              smp_valid = 1'b0;
  logic              smp_pend = 1'b0;
  logic [11:0]       smp_s1 = 12'hA50;
  logic [11:0]       smp_s2 = 12'h3E7;
  logic [11:0]       comp_data;
  logic [2:0]        hr_low = 3'h0;
  logic [2:0]        hr_high = 3'h0;
  logic              led_over_30ma = 1'b0;
  logic              standalone = 1'b0;
  logic              peak_reached = 1'b0;
  logic              chip_active;
  logic              conv_run;
  logic              soft_start_active;
  logic              sink_enable;
  logic              window_upper_sel;
  logic [4:0]        vout_code;
  logic              sw_gate;
  int                n_errors = 0;
  int                n_checks = 0;

  always #2.5 mclk = ~mclk;

  bac_top #(.SOFT_CYC(SOFT), .SAMPLE_CYC(SMP)) dut (
    .mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .conv_start(conv_start), .smp_valid(smp_valid),
    .smp_s1(smp_s1), .smp_s2(smp_s2), .comp_data(comp_data), .hr_low(hr_low),
    .hr_high(hr_high), .led_over_30ma(led_over_30ma), .standalone(standalone),
    .peak_reached(peak_reached), .chip_active(chip_active), .conv_run(conv_run),
    .soft_start_active(soft_start_active), .sink_enable(sink_enable),
    .window_upper_sel(window_upper_sel), .vout_code(vout_code), .sw_gate(sw_gate)
  );

  bac_host_model host (
    .mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  // Each start request gets one sample two cycles later; input one alternates so
  // that only a true mean gives the expected result.
  always @(negedge mclk) begin
    smp_valid <= smp_pend;
    smp_pend  <= conv_start;
    if (smp_pend) smp_s1 <= smp_s1 ^ 12'h038;
  end

  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk({name, "_valid"}, 12'h001, 12'(v));
    chk(name, 12'(exp), 12'(d));
  endtask

  // Start requests are one-cycle pulses, so each one is seen at exactly one falling edge.
  task automatic count_starts(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if (conv_start === 1'b1) c++;
    end
    chk("conv_start", 12'(exp), 12'(c));
  endtask

  task automatic wait_code(input logic [4:0] exp, input int lim);
    for (int i = 0; i < lim && vout_code !== exp; i++) @(negedge mclk);
    chk("vout_code", 12'(exp), 12'(vout_code));
  endtask

  task automatic t_reset();
    rdc(bac_pkg::ADR_CTRL, 8'h04, "ctrl");
    rdc(bac_pkg::ADR_VOUT, 8'h00, "vout");
    rdc(bac_pkg::ADR_LED_EN, 8'h00, "led_en");
    rdc(7'h33, 8'h00, "unmapped");
    chk("vout_code", 12'h005, 12'(vout_code));
    chk("chip_active", 12'h000, 12'(chip_active));
    chk("conv_run", 12'h000, 12'(conv_run));
    count_starts(SMP * 3, 0);
  endtask

  task automatic t_ctrl();
    host.wr(bac_pkg::ADR_CTRL, 8'hC9);
    cyc(2);
    chk("chip_active", 12'h001, 12'(chip_active));
    chk("sink_enable", 12'h001, 12'(sink_enable));
    chk("conv_run", 12'h000, 12'(conv_run));
    rdc(bac_pkg::ADR_CTRL, 8'h09, "ctrl");
    count_starts(SMP * 4, 4);
    host.wr(bac_pkg::ADR_CTRL, 8'h01);
    cyc(2);
    chk("sink_enable", 12'h000, 12'(sink_enable));
  endtask

  task automatic t_soft();
    for (int k = 0; k < 2; k++) begin
      host.wr(bac_pkg::ADR_CTRL, 8'h03);
      cyc(3);
      chk("conv_run", 12'h001, 12'(conv_run));
      chk("soft_start", 12'h001, 12'(soft_start_active));
      cyc(SOFT - 10);
      chk("soft_start", 12'h001, 12'(soft_start_active));
      cyc(20);
      chk("soft_start", 12'h000, 12'(soft_start_active));
      chk("conv_run", 12'h001, 12'(conv_run));
      host.wr(bac_pkg::ADR_CTRL, 8'h01);
      cyc(3);
      chk("conv_run", 12'h000, 12'(conv_run));
    end
    host.wr(bac_pkg::ADR_CTRL, 8'h03);
    cyc(SOFT + 10);
  endtask

  task automatic t_manual();
    logic [7:0] w [8] = '{8'h00, 8'h04, 8'h05, 8'h0C, 8'h13, 8'h14, 8'h15, 8'hFF};
    logic [4:0] e [8] = '{5'h05, 5'h05, 5'h05, 5'h0C, 5'h13, 5'h14, 5'h14, 5'h14};
    for (int i = 0; i < 8; i++) begin
      host.wr(bac_pkg::ADR_VOUT, w[i]);
      cyc(3);
      chk("vout_code", 12'(e[i]), 12'(vout_code));
    end
    rdc(bac_pkg::ADR_VOUT, 8'hFF, "vout");
    host.wr(bac_pkg::ADR_VOUT, 8'h0C);
  endtask

  task automatic pulse(input logic pk, input int exp_hi);
    int hi;
    int per;
    peak_reached = pk;
    cyc(410);
    hi = 0;
    for (int i = 0; i < 400 && sw_gate !== 1'b0; i++) @(negedge mclk);
    for (int i = 0; i < 400 && sw_gate !== 1'b1; i++) @(negedge mclk);
    while (sw_gate === 1'b1 && hi < 400) begin
      hi++;
      @(negedge mclk);
    end
    per = hi;
    while (sw_gate === 1'b0 && per < 400) begin
      per++;
      @(negedge mclk);
    end
    chk("gate_high", 12'(exp_hi), 12'(hi));
    chk("gate_period", 12'(bac_pkg::SW_PERIOD_CYC), 12'(per));
  endtask

  task automatic t_meas();
    logic [11:0] r;
    logic [1:0]  v;
    cyc(SMP * 40);
    host.rd_conv(r, v);
    chk("conv_s1", 12'hA5C, r);
    chk("conv_valid", 12'h003, 12'(v));
    chk("comp_data", 12'hA5C, comp_data);
    host.wr(bac_pkg::ADR_CTRL, 8'h33);
    cyc(3);
    chk("comp_data", 12'h3E7, comp_data);
    rdc(bac_pkg::ADR_CONV_HI, 8'h03, "conv_hi");
    smp_s2 = 12'h81F;
    cyc(SMP * 40);
    rdc(bac_pkg::ADR_CONV_LO, 8'hE7, "conv_lo");
    host.wr(bac_pkg::ADR_CTRL, 8'h23);
    cyc(3);
    chk("comp_data", 12'hA5C, comp_data);
    rdc(bac_pkg::ADR_CONV_HI, 8'h08, "conv_hi");
    rdc(bac_pkg::ADR_CONV_LO, 8'h1F, "conv_lo");
  endtask

  task automatic t_adapt();
    host.wr(bac_pkg::ADR_CTRL, 8'h07);
    host.wr(bac_pkg::ADR_LED_EN, 8'hF9);
    rdc(bac_pkg::ADR_LED_EN, 8'h01, "led_en");
    hr_low = 3'b110;
    cyc(4200);
    chk("vout_code", 12'h005, 12'(vout_code));
    hr_low = 3'b001;
    wait_code(5'h06, 2100);
    host.wr(bac_pkg::ADR_VOUT, 8'h10);
    cyc(3);
    chk("vout_code", 12'h006, 12'(vout_code));
    wait_code(5'h14, 34000);
    cyc(4100);
    chk("vout_code", 12'h014, 12'(vout_code));
    led_over_30ma = 1'b1;
    cyc(8);
    chk("window_upper", 12'h001, 12'(window_upper_sel));
    led_over_30ma = 1'b0;
    cyc(8);
    chk("window_upper", 12'h000, 12'(window_upper_sel));
    hr_low = 3'b000;
    hr_high = 3'b001;
    wait_code(5'h13, 2100);
    hr_high = 3'b110;
    cyc(4100);
    chk("vout_code", 12'h013, 12'(vout_code));
    host.wr(bac_pkg::ADR_CTRL, 8'h03);
    cyc(3);
    chk("vout_code", 12'h010, 12'(vout_code));
    standalone = 1'b1;
    cyc(8);
    chk("vout_code", 12'h013, 12'(vout_code));
    standalone = 1'b0;
    host.wr(bac_pkg::ADR_LED_EN, 8'h00);
    host.wr(bac_pkg::ADR_CTRL, 8'h01);
    cyc(3);
    chk("conv_run", 12'h000, 12'(conv_run));
  endtask

  // The full sequence takes about 46000 cycles.
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    test_done();
  end

  initial begin
    cyc(12);
    srst = 1'b0;
    t_reset();
    t_ctrl();
    t_soft();
    t_manual();
    pulse(1'b1, bac_pkg::MIN_PULSE_CYC);
    pulse(1'b0, bac_pkg::MAX_PULSE_CYC);
    t_meas();
    t_adapt();
    test_done();
  end
endmodule
`default_nettype wire

// File: verilog/bac_avg.sv
`timescale 1ns/1ps
`default_nettype none
module bac_avg (
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // Raw samples.
  input  wire logic                      smp_valid,
  input  wire logic [bac_pkg::CONV_W-1:0] smp_data,
  // Averaged result.
  output logic      [bac_pkg::CONV_W-1:0] avg_q
);

  localparam int ACC_W = bac_pkg::CONV_W + bac_pkg::AVG_SHIFT;

  logic [ACC_W-1:0]               acc_q;
  logic [bac_pkg::AVG_SHIFT-1:0]  cnt_q;
  logic [ACC_W-1:0]               sum;

  assign sum = acc_q + {{bac_pkg::AVG_SHIFT{1'b0}}, smp_data};

  // Sixteen samples are summed and the sum is shifted down to the mean.
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_q <= '0;
      cnt_q <= '0;
      avg_q <= '0;
    end else if (smp_valid) begin
      cnt_q <= cnt_q + 1'b1;
      if (&cnt_q) begin
        avg_q <= sum[ACC_W-1:bac_pkg::AVG_SHIFT];
        acc_q <= '0;
      end else begin
        acc_q <= sum;
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/bac_pkg.sv
package bac_pkg;

  // Register offsets.
  localparam logic [6:0] ADR_LED_EN  = 7'h00;
  localparam logic [6:0] ADR_VOUT    = 7'h05;
  localparam logic [6:0] ADR_CTRL    = 7'h06;
  localparam logic [6:0] ADR_CONV_HI = 7'h0E;
  localparam logic [6:0] ADR_CONV_LO = 7'h0F;

  // Control register fields.
  localparam int CTRL_ACTIVE   = 0;
  localparam int CTRL_RUN      = 1;
  localparam int CTRL_ADAPT    = 2;
  localparam int CTRL_SINK     = 3;
  localparam int CTRL_COMP_SEL = 4;
  localparam int CTRL_VIEW_SEL = 5;
  localparam int CTRL_W        = 6;
  localparam int LED_EN_W      = 3;

  // Reset values.
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 6'h04;
  localparam logic [7:0]          VOUT_RST   = 8'h00;
  localparam logic [LED_EN_W-1:0] LED_EN_RST = 3'h0;

  // Voltage code limits in volts.
  localparam logic [7:0] VCODE_MIN = 8'h05;
  localparam logic [7:0] VCODE_MAX = 8'h14;

  // Measurement widths.
  localparam int CONV_W    = 12;
  localparam int AVG_SHIFT = 4;
  localparam int AVG_N     = 16;

  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SW_FREQ_KHZ   = 1000;
  localparam int SW_PERIOD_CYC = 1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int MIN_PULSE_NS  = 50;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_DUTY_PCT  = 90;
  localparam int MAX_PULSE_CYC = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int SOFT_DUTY_PCT = 25;
  localparam int SOFT_PULSE_CYC = SW_PERIOD_CYC * SOFT_DUTY_PCT / 100;
  localparam int SOFT_MS       = 50;
  localparam int AVG_MS        = 134;
  localparam int ADJ_PERIOD_CYC = 2000;
  localparam int SW_CNT_W      = 8;
  localparam int LONG_CNT_W    = 24;
  localparam int ADJ_CNT_W     = 11;

  // Register access request from the serial port.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bac_req_t;

  // Converter sequencing.
  typedef enum logic [2:0] {
    CNV_OFF    = 3'b001,
    CNV_SOFT   = 3'b010,
    CNV_NORMAL = 3'b100
  } bac_cnv_state_t;

endpackage

// File: verilog/bac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two sensor inputs give 12-bit results.
// - Results averaged over a 134 ms window.
// - View select picks readable sensor result.
// - Compensation source select picks sensor input.
// - Control register bits; chip_active zero means standby.
// - Light-load sink enable drives internal load.
// - Run enable zero holds converter in standby.
// - Run enable write starts 50 ms soft start.
// - Manual code sets target in 1 V steps.
// - Code clamped to 5 through 20.
// - Adaptive mode ignores the stored voltage code.
// - Adaptive steers from lowest enabled output headroom.
// - Headroom window widens above 30 mA.
// - Adaptive target limited to 5..20 V.
// - Adaptive select reads one after reset.
// - Stand-alone operation forces adaptive control.
// - Switch clock runs at 1 MHz.
// - Minimum 50 ns pulse every cycle.
// - Duty cycle limited by digital logic.
// - LED enables define sensed outputs.
module bac_top #(
  parameter int SOFT_CYC   = bac_pkg::SOFT_MS * 1000000 / bac_pkg::CLK_PERIOD_NS,
  parameter int SAMPLE_CYC = bac_pkg::AVG_MS * 1000000 / bac_pkg::CLK_PERIOD_NS
                             / bac_pkg::AVG_N
) (
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // Register port.
  input  wire bac_pkg::bac_req_t         reg_req,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_rvalid,
  // Measurement converter.
  output logic                           conv_start,
  input  wire logic                      smp_valid,
  input  wire logic [bac_pkg::CONV_W-1:0] smp_s1,
  input  wire logic [bac_pkg::CONV_W-1:0] smp_s2,
  output logic      [bac_pkg::CONV_W-1:0] comp_data,
  // Analog comparators and pins.
  input  wire logic [2:0]                hr_low,
  input  wire logic [2:0]                hr_high,
  input  wire logic                      led_over_30ma,
  input  wire logic                      standalone,
  input  wire logic                      peak_reached,
  // Power stage controls.
  output logic                           chip_active,
  output logic                           conv_run,
  output logic                           soft_start_active,
  output logic                           sink_enable,
  output logic                           window_upper_sel,
  output logic      [4:0]                vout_code,
  output logic                           sw_gate
);

  localparam int NSYNC = 9;
  localparam int SW_PER_A = bac_pkg::SW_PERIOD_CYC;

  logic [bac_pkg::CTRL_W-1:0]   ctrl_q;
  logic [7:0]                   vout_q;
  logic [bac_pkg::LED_EN_W-1:0] led_en_q;
  logic [7:0]                   lo_q;
  logic [NSYNC-1:0]             async_in;
  logic [NSYNC-1:0]             s1_q;
  logic [NSYNC-1:0]             s2_q;
  logic [NSYNC-1:0]             s3_q;
  logic [NSYNC-1:0]             clean_q;
  logic [2:0]                   hr_low_s;
  logic [2:0]                   hr_high_s;
  logic                         over_s;
  logic                         alone_s;
  logic                         peak_s;
  logic [bac_pkg::CONV_W-1:0]   avg1;
  logic [bac_pkg::CONV_W-1:0]   avg2;
  logic [bac_pkg::CONV_W-1:0]   view;
  logic [bac_pkg::LONG_CNT_W-1:0] smp_cnt_q;
  logic [bac_pkg::LONG_CNT_W-1:0] soft_cnt_q;
  bac_pkg::bac_cnv_state_t      cnv_q;
  bac_pkg::bac_cnv_state_t      cnv_d;
  logic                         run_req;
  logic                         adaptive_eff;
  logic [7:0]                   manual_code;
  logic [7:0]                   auto_q;
  logic [bac_pkg::ADJ_CNT_W-1:0] adj_cnt_q;
  logic                         adj_tick;
  logic                         any_low;
  logic                         all_high;
  logic [bac_pkg::SW_CNT_W-1:0] sw_cnt_q;
  logic [bac_pkg::SW_CNT_W-1:0] pulse_lim;
  logic                         sw_run;
  logic [bac_pkg::SW_CNT_W-1:0] hi_len_q;

  // Register writes.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q   <= bac_pkg::CTRL_RST;
      vout_q   <= bac_pkg::VOUT_RST;
      led_en_q <= bac_pkg::LED_EN_RST;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        bac_pkg::ADR_CTRL:   ctrl_q   <= reg_req.wdata[bac_pkg::CTRL_W-1:0];
        bac_pkg::ADR_VOUT:   vout_q   <= reg_req.wdata;
        bac_pkg::ADR_LED_EN: led_en_q <= reg_req.wdata[bac_pkg::LED_EN_W-1:0];
        default: ;
      endcase
    end
  end

  assign view = ctrl_q[bac_pkg::CTRL_VIEW_SEL] ? avg2 : avg1;

  // Register reads; an upper byte read freezes the matching lower byte.
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
      lo_q       <= 8'h00;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          bac_pkg::ADR_CTRL:    reg_rdata <= {2'h0, ctrl_q};
          bac_pkg::ADR_VOUT:    reg_rdata <= vout_q;
          bac_pkg::ADR_LED_EN:  reg_rdata <= {5'h00, led_en_q};
          bac_pkg::ADR_CONV_HI: begin
            reg_rdata <= {4'h0, view[bac_pkg::CONV_W-1:8]};
            lo_q      <= view[7:0];
          end
          bac_pkg::ADR_CONV_LO: reg_rdata <= lo_q;
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Pin inputs pass three flops and count once the last two agree.
  assign async_in = {hr_low, hr_high, led_over_30ma, standalone, peak_reached};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (srst) begin
          s1_q[gi]    <= 1'b0;
          s2_q[gi]    <= 1'b0;
          s3_q[gi]    <= 1'b0;
          clean_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            clean_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  assign hr_low_s  = clean_q[8:6];
  assign hr_high_s = clean_q[5:3];
  assign over_s    = clean_q[2];
  assign alone_s   = clean_q[1];
  assign peak_s    = clean_q[0];

  // Conversion requests spread sixteen samples over the averaging window.
  always_ff @(posedge mclk) begin
    if (srst || !ctrl_q[bac_pkg::CTRL_ACTIVE]) begin
      smp_cnt_q  <= '0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= (smp_cnt_q == bac_pkg::LONG_CNT_W'(SAMPLE_CYC - 1));
      if (smp_cnt_q == bac_pkg::LONG_CNT_W'(SAMPLE_CYC - 1)) begin
        smp_cnt_q <= '0;
      end else begin
        smp_cnt_q <= smp_cnt_q + 1'b1;
      end
    end
  end

  // One averaging filter per sensor input.
  bac_avg u_avg1 (
    .mclk      (mclk),
    .srst      (srst),
    .smp_valid (smp_valid),
    .smp_data  (smp_s1),
    .avg_q     (avg1)
  );

  bac_avg u_avg2 (
    .mclk      (mclk),
    .srst      (srst),
    .smp_valid (smp_valid),
    .smp_data  (smp_s2),
    .avg_q     (avg2)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      comp_data <= '0;
    end else begin
      comp_data <= ctrl_q[bac_pkg::CTRL_COMP_SEL] ? avg2 : avg1;
    end
  end

  // Converter sequencing: off, soft start, normal.
  assign run_req = ctrl_q[bac_pkg::CTRL_ACTIVE] & ctrl_q[bac_pkg::CTRL_RUN];

  always_comb begin
    cnv_d = cnv_q;
    unique case (cnv_q)
      bac_pkg::CNV_OFF: begin
        if (run_req) begin
          cnv_d = bac_pkg::CNV_SOFT;
        end
      end
      bac_pkg::CNV_SOFT: begin
        if (!run_req) begin
          cnv_d = bac_pkg::CNV_OFF;
        end else if (soft_cnt_q == bac_pkg::LONG_CNT_W'(SOFT_CYC - 1)) begin
          cnv_d = bac_pkg::CNV_NORMAL;
        end
      end
      bac_pkg::CNV_NORMAL: begin
        if (!run_req) begin
          cnv_d = bac_pkg::CNV_OFF;
        end
      end
      default: cnv_d = bac_pkg::CNV_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnv_q <= bac_pkg::CNV_OFF;
    end else begin
      cnv_q <= cnv_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cnv_q != bac_pkg::CNV_SOFT) begin
      soft_cnt_q <= '0;
    end else begin
      soft_cnt_q <= soft_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      chip_active       <= 1'b0;
      conv_run          <= 1'b0;
      soft_start_active <= 1'b0;
      sink_enable       <= 1'b0;
      window_upper_sel  <= 1'b0;
    end else begin
      chip_active       <= ctrl_q[bac_pkg::CTRL_ACTIVE];
      conv_run          <= (cnv_q != bac_pkg::CNV_OFF);
      soft_start_active <= (cnv_q == bac_pkg::CNV_SOFT);
      sink_enable       <= ctrl_q[bac_pkg::CTRL_ACTIVE] & ctrl_q[bac_pkg::CTRL_SINK];
      window_upper_sel  <= over_s;
    end
  end

  // Output voltage target.
  assign adaptive_eff = ctrl_q[bac_pkg::CTRL_ADAPT] | alone_s;
  assign manual_code  = (vout_q < bac_pkg::VCODE_MIN) ? bac_pkg::VCODE_MIN :
                        (vout_q > bac_pkg::VCODE_MAX) ? bac_pkg::VCODE_MAX : vout_q;
  assign any_low  = |(hr_low_s & led_en_q);
  assign all_high = (|led_en_q) & (&(hr_high_s | ~led_en_q));
  assign adj_tick = (adj_cnt_q == bac_pkg::ADJ_CNT_W'(bac_pkg::ADJ_PERIOD_CYC - 1));

  always_ff @(posedge mclk) begin
    if (srst || adj_tick) begin
      adj_cnt_q <= '0;
    end else begin
      adj_cnt_q <= adj_cnt_q + 1'b1;
    end
  end

  // Adaptive code climbs while any enabled output lacks headroom and falls
  // only when every enabled output has surplus, so the lowest one sets it.
  always_ff @(posedge mclk) begin
    if (srst || cnv_q == bac_pkg::CNV_OFF) begin
      auto_q <= bac_pkg::VCODE_MIN;
    end else if (adj_tick && adaptive_eff) begin
      if (any_low && auto_q < bac_pkg::VCODE_MAX) begin
        auto_q <= auto_q + 8'h01;
      end else if (!any_low && all_high && auto_q > bac_pkg::VCODE_MIN) begin
        auto_q <= auto_q - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      vout_code <= bac_pkg::VCODE_MIN[4:0];
    end else begin
      vout_code <= adaptive_eff ? auto_q[4:0] : manual_code[4:0];
    end
  end

  // Switch timing: fixed period, minimum pulse, digital duty limit.
  assign sw_run    = (cnv_q != bac_pkg::CNV_OFF);
  assign pulse_lim = (cnv_q == bac_pkg::CNV_SOFT) ?
                     bac_pkg::SW_CNT_W'(bac_pkg::SOFT_PULSE_CYC) :
                     bac_pkg::SW_CNT_W'(bac_pkg::MAX_PULSE_CYC);

  always_ff @(posedge mclk) begin
    if (srst || !sw_run || sw_cnt_q == bac_pkg::SW_CNT_W'(bac_pkg::SW_PERIOD_CYC - 1)) begin
      sw_cnt_q <= '0;
    end else begin
      sw_cnt_q <= sw_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !sw_run) begin
      sw_gate <= 1'b0;
    end else if (sw_cnt_q == bac_pkg::SW_CNT_W'(bac_pkg::SW_PERIOD_CYC - 1)) begin
      sw_gate <= 1'b1;
    end else if (sw_gate && sw_cnt_q >= bac_pkg::SW_CNT_W'(bac_pkg::MIN_PULSE_CYC - 1)
                 && (peak_s || sw_cnt_q >= pulse_lim - 1'b1)) begin
      sw_gate <= 1'b0;
    end
  end

  // Helper for checking pulse width.
  always_ff @(posedge mclk) begin
    if (srst || !sw_gate) begin
      hi_len_q <= '0;
    end else begin
      hi_len_q <= hi_len_q + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_hi_read;
    reg_req.rd && reg_req.addr == bac_pkg::ADR_CONV_HI;
  endsequence

  sequence s_lo_read;
    reg_req.rd && reg_req.addr == bac_pkg::ADR_CONV_LO;
  endsequence

  a_view_upper: assert property (
    s_hi_read |=> reg_rdata == {4'h0, $past(view[bac_pkg::CONV_W-1:8])})
    else $error("upper byte does not match selected result");

  a_pair_lower: assert property (
    s_hi_read ##1 !reg_req.rd ##1 s_lo_read |=> reg_rdata == $past(view[7:0], 3))
    else $error("lower byte not from same result as upper byte");

  a_comp_source: assert property (
    ##1 comp_data == $past(ctrl_q[bac_pkg::CTRL_COMP_SEL] ? avg2 : avg1))
    else $error("compensation data from wrong input");

  a_sink_follow: assert property (
    ##1 sink_enable == $past(ctrl_q[bac_pkg::CTRL_SINK] & ctrl_q[bac_pkg::CTRL_ACTIVE]))
    else $error("light-load sink does not follow its enable");

  a_run_standby: assert property (
    !run_req [*2] |=> !conv_run && !sw_gate)
    else $error("converter runs while disabled");

  a_soft_start: assert property (
    (cnv_q == bac_pkg::CNV_OFF && run_req) |=> cnv_q == bac_pkg::CNV_SOFT ##1
      (soft_start_active && pulse_lim == bac_pkg::SW_CNT_W'(bac_pkg::SOFT_PULSE_CYC)))
    else $error("soft start not entered on run enable");

  a_code_clamp: assert property (
    vout_code >= bac_pkg::VCODE_MIN[4:0] && vout_code <= bac_pkg::VCODE_MAX[4:0])
    else $error("voltage code outside 5 to 20");

  a_manual_code: assert property (
    !adaptive_eff |=> vout_code == $past(manual_code[4:0]))
    else $error("manual voltage code not applied");

  a_adapt_up: assert property (
    (adj_tick && adaptive_eff && any_low && sw_run && auto_q < bac_pkg::VCODE_MAX)
      |=> auto_q == $past(auto_q) + 8'h01)
    else $error("adaptive code did not rise on low headroom");

  a_pulse_width: assert property (
    $fell(sw_gate) && $past(sw_run) |-> $past(hi_len_q) >= bac_pkg::SW_CNT_W'(bac_pkg::MIN_PULSE_CYC - 1)
      && $past(hi_len_q) < bac_pkg::SW_CNT_W'(bac_pkg::MAX_PULSE_CYC))
    else $error("switch pulse width out of range");

  a_sw_period: assert property (
    $rose(sw_gate) |-> ##SW_PER_A ($rose(sw_gate) || !conv_run || !sw_run))
    else $error("switching period is not 200 cycles");

endmodule
`default_nettype wire
